// ### src/timer2_reload_capture_baud.sv
`timescale 1ns/1ns
// Function
// - Capture mode with trigger enabled copies count to reload register on trigger fall.
// - Reload mode reloads on overflow, and on trigger fall when trigger enabled.
// - Any baud select set forces reload on overflow, ignoring capture select.
// - Port B has its own receive and transmit baud selects, same behaviour.
// - Capture select set, trigger disabled, running: plain 16-bit up counter.
// - Timer counts at clock/12; outside baud mode the counter counts pin edges, at most clock/2.
// - Baud mode never raises the overflow flag.
// - Baud mode with trigger enabled: trigger fall raises external flag.
// - Transmit select 0 uses other timer, 1 uses this timer's overflows.
// - Receive select picks its source the same way as transmit.
// - Receive and transmit sources are chosen independently.
// - Baud mode reloads both count bytes from reload register on rollover.
// - Baud mode timer operation advances at clock/2 instead of clock/12.
// - Serial baud clock equals this timer's overflow rate divided by 16.
// - Baud mode trigger fall sets external flag but never reloads.
module timer2_reload_capture_baud
   import timer2_pkg::*;
(
   input  wire logic        i_clock,               // 50 MHz system clock.
   input  wire logic        i_rst_b,               // Synchronous reset, active low.
   input  wire logic        i_timer_run,           // Run bit.
   input  wire logic        i_counter_mode,        // 1 counts the pin outside baud mode, 0 counts clocks.
   input  wire logic        i_capture_select,      // 1 capture, 0 reload.
   input  wire logic        i_trigger_enable,      // Enables trigger pin action.
   input  wire logic        i_rx_baud_select,      // Port A receive source.
   input  wire logic        i_tx_baud_select,      // Port A transmit source.
   input  wire logic        i_rx_baud_select_port1, // Port B receive source.
   input  wire logic        i_tx_baud_select_port1, // Port B transmit source.
   input  wire logic        i_trigger_pin,         // Asynchronous trigger pin.
   input  wire logic        i_count_input_pin,     // Asynchronous count pin.
   input  wire logic        i_other_timer_tick,    // Baud tick from other timer.
   input  wire logic        i_count_write,         // Loads the count.
   input  wire logic        i_reload_write,        // Loads the reload register.
   input  wire logic [15:0] i_write_data,          // Data for the two writes.
   input  wire logic        i_overflow_clear,      // Clears overflow flag.
   input  wire logic        i_external_clear,      // Clears external flag.
   output logic [15:0]      o_count,               // Count high and low bytes.
   output logic [15:0]      o_reload,              // Reload or capture register.
   output logic             o_overflow_flag,       // Sticky overflow flag.
   output logic             o_external_flag,       // Sticky trigger flag.
   output logic             o_baud_mode,           // Baud generator mode active.
   output logic             o_rx_clock_port_a,     // Port A receive baud tick.
   output logic             o_tx_clock_port_a,     // Port A transmit baud tick.
   output logic             o_rx_clock_port_b,     // Port B receive baud tick.
   output logic             o_tx_clock_port_b      // Port B transmit baud tick.
);
   // Pin synchronisers; the first stage feeds only the second.
   logic [1:0] trig_sync;
   logic [1:0] cnt_sync;
   logic       trig_last;
   logic       cnt_last;
   logic [3:0] prescale;
   logic [3:0] next_prescale;
   logic [15:0] next_count;
   logic [15:0] next_reload;
   logic        next_overflow_flag;
   logic        next_external_flag;
   logic        trig_fall;
   logic        cnt_fall;
   logic        step;
   logic        overflow;
   logic        baud_tick;
   mode_t       mode;

   // Synchronises the pins and keeps the previous sampled level.
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_b)
      begin
         trig_sync <= 2'b11;
         cnt_sync  <= 2'b11;
         trig_last <= 1'b1;
         cnt_last  <= 1'b1;
      end
      else
      begin
         trig_sync <= {trig_sync[0], i_trigger_pin};
         cnt_sync  <= {cnt_sync[0], i_count_input_pin};
         trig_last <= trig_sync[1];
         cnt_last  <= cnt_sync[1];
      end
   end

   // Mode decode: baud selects override the capture select.
   always_comb
   begin
      if (o_baud_mode)
         mode = MODE_BAUD;
      else if (!i_capture_select)
         mode = MODE_RELOAD;
      else if (i_trigger_enable)
         mode = MODE_CAPTURE;
      else
         mode = MODE_FREE;
   end

   // Either port's pair of selects puts the timer in baud mode, since both pairs act alike.
   assign o_baud_mode = i_rx_baud_select | i_tx_baud_select | i_rx_baud_select_port1 | i_tx_baud_select_port1;
   assign trig_fall   = trig_last & ~trig_sync[1];
   assign cnt_fall    = cnt_last & ~cnt_sync[1];
   assign overflow    = step && (o_count == COUNT_MAX);
   assign baud_tick   = overflow && (mode == MODE_BAUD);

   // Prescaler and count step selection.
   // The limit test uses >= so that a switch from the slow to the fast ratio in mid-count
   // steps at once instead of running the four-bit prescaler through its wrap.
   always_comb
   begin
      next_prescale = prescale;
      step          = 1'b0;
      if (!i_timer_run)
         next_prescale = 4'h0;
      else if (i_counter_mode && mode != MODE_BAUD)
         step = cnt_fall;
      else if (prescale >= ((mode == MODE_BAUD) ? PRESCALE_BAUD : PRESCALE_TIMER))
      begin
         next_prescale = 4'h0;
         step          = 1'b1;
      end
      else
         next_prescale = prescale + 4'h1;
   end

   // Count, reload register and flags.
   always_comb
   begin
      next_count         = o_count;
      next_reload        = o_reload;
      next_overflow_flag = o_overflow_flag & ~i_overflow_clear;
      next_external_flag = o_external_flag & ~i_external_clear;
      if (step)
         next_count = o_count + 16'h0001;
      if (overflow)
      begin
         if (mode == MODE_BAUD || mode == MODE_RELOAD)
            next_count = o_reload;
         if (mode != MODE_BAUD)
            next_overflow_flag = 1'b1;
      end
      if (i_timer_run && i_trigger_enable && trig_fall)
      begin
         next_external_flag = 1'b1;
         unique case (mode)
            MODE_RELOAD:  next_count  = o_reload;
            MODE_CAPTURE: next_reload = o_count;
            MODE_FREE:    next_count  = next_count;
            MODE_BAUD:    next_count  = next_count;
         endcase
      end
      if (i_count_write)
         next_count = i_write_data;
      if (i_reload_write)
         next_reload = i_write_data;
   end

   // Registers the counter state.
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_b)
      begin
         prescale        <= 4'h0;
         o_count         <= COUNT_RESET;
         o_reload        <= RELOAD_RESET;
         o_overflow_flag <= 1'b0;
         o_external_flag <= 1'b0;
      end
      else
      begin
         prescale        <= next_prescale;
         o_count         <= next_count;
         o_reload        <= next_reload;
         o_overflow_flag <= next_overflow_flag;
         o_external_flag <= next_external_flag;
      end
   end

   // Baud outputs per direction and port: divide by 16 when this timer is picked.
   logic [3:0] sel;
   logic [3:0] tick_out;
   assign sel = {i_tx_baud_select_port1, i_rx_baud_select_port1, i_tx_baud_select, i_rx_baud_select};
   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : gen_baud
         logic div_tick;
         baud_divider #(.RATIO(BAUD_DIVIDE)) u_div
         (
            .i_clock (i_clock),
            .i_rst_b (i_rst_b),
            .i_tick  (overflow && sel[g]),
            .o_tick  (div_tick)
         );
         assign tick_out[g] = sel[g] ? div_tick : i_other_timer_tick;
      end
   endgenerate
   assign o_rx_clock_port_a = tick_out[0];
   assign o_tx_clock_port_a = tick_out[1];
   assign o_rx_clock_port_b = tick_out[2];
   assign o_tx_clock_port_b = tick_out[3];

   // Checks on the counter behaviour.
   AST_STOP: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      !i_timer_run && !i_count_write |=> o_count == $past(o_count))
      else $error("Count moved while stopped.");
   AST_NO_OVF_BAUD: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      baud_tick && !o_overflow_flag |=> !o_overflow_flag)
      else $error("Overflow flag set in baud mode.");
   AST_BAUD_RELOAD: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      baud_tick && !i_count_write |=> o_count == $past(o_reload))
      else $error("Baud rollover did not reload.");
   AST_CAPTURE: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      i_timer_run && mode == MODE_CAPTURE && trig_fall && !i_reload_write |=> o_reload == $past(o_count))
      else $error("Capture missed.");
   AST_RELOAD_OVF: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      overflow && mode == MODE_RELOAD && !i_count_write |=> o_count == $past(o_reload) && o_overflow_flag)
      else $error("Reload on overflow missed.");
   AST_EXT_FLAG: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      i_timer_run && i_trigger_enable && trig_fall |=> o_external_flag)
      else $error("External flag not set.");
   AST_BAUD_RATE: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      i_timer_run && mode == MODE_BAUD && !i_count_write && !i_counter_mode ##1
      i_timer_run && mode == MODE_BAUD && !i_count_write |=> o_count != $past(o_count, 2))
      else $error("Baud rate step too slow.");
   AST_FREE: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      overflow && mode == MODE_FREE && !i_count_write |=> o_count == 16'h0000)
      else $error("Free count did not wrap.");
   AST_TX_SRC: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      !i_tx_baud_select |-> o_tx_clock_port_a == i_other_timer_tick)
      else $error("Transmit source wrong.");
endmodule

// ### src/timer2_pkg.sv
package timer2_pkg;
   // Counter geometry and reset values.
   localparam int             COUNT_WIDTH    = 16;
   localparam logic [15:0]    COUNT_RESET    = 16'h0000;
   localparam logic [15:0]    RELOAD_RESET   = 16'h0000;
   localparam logic [15:0]    COUNT_MAX      = 16'hFFFF;
   // Clock rate and prescale ratios in oscillator cycles per count.
   localparam int             CLOCK_HZ       = 50_000_000;
   localparam int             DIV_TIMER      = 12;
   localparam int             DIV_BAUD       = 2;
   localparam int             DIV_PIN_MIN    = 24;
   localparam int             BAUD_DIVIDE    = 16;
   localparam int             PRESCALE_WIDTH = 4;
   localparam logic [3:0]     PRESCALE_TIMER = 4'(DIV_TIMER - 1);
   localparam logic [3:0]     PRESCALE_BAUD  = 4'(DIV_BAUD - 1);
   localparam logic [3:0]     BAUD_DIV_LAST  = 4'(BAUD_DIVIDE - 1);
   // Operating modes.
   typedef enum logic [1:0] {MODE_RELOAD, MODE_CAPTURE, MODE_FREE, MODE_BAUD} mode_t;
endpackage

// ### src/baud_divider.sv
`timescale 1ns/1ns
// Divides the overflow pulse stream by a fixed ratio for one baud clock.
module baud_divider
   import timer2_pkg::*;
#(
   parameter int RATIO = BAUD_DIVIDE
)
(
   input  wire logic i_clock,     // System clock.
   input  wire logic i_rst_b,     // Synchronous reset, active low.
   input  wire logic i_tick,      // Overflow pulse in.
   output logic      o_tick       // One pulse per RATIO input pulses.
);
   // Refuses at elaboration a ratio that the four-bit count cannot serve.
   generate
      if (RATIO < 2 || RATIO > 16)
      begin : gen_bad_ratio
         $error("RATIO out of range");
      end
   endgenerate

   logic [3:0] count;
   logic [3:0] next_count;
   logic       next_tick;

   // Counts input pulses and fires on the last of each group.
   always_comb
   begin
      next_count = count;
      next_tick  = 1'b0;
      if (i_tick)
      begin
         if (count == 4'(RATIO - 1))
         begin
            next_count = 4'h0;
            next_tick  = 1'b1;
         end
         else
            next_count = count + 4'h1;
      end
   end

   // Registers the divider state.
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_b)
      begin
         count  <= 4'h0;
         o_tick <= 1'b0;
      end
      else
      begin
         count  <= next_count;
         o_tick <= next_tick;
      end
   end
endmodule

// ### bench/baud_partner.sv
`timescale 1ns/1ns
// Stands in for the serial ports: makes the other timer's baud tick and counts received ticks.
module baud_partner
#(
   parameter int PERIOD = 10
)
(
   input  wire logic i_clock,   // System clock.
   input  wire logic i_rst_b,   // Synchronous reset, active low.
   input  wire logic [3:0] i_ticks, // Baud ticks of both ports.
   output logic      o_other,   // One-cycle tick from the other timer.
   output int        o_ticks    // Ticks seen on all four baud inputs.
);
   int div;

   // The other timer ticks once every PERIOD cycles; a port sees every tick it is handed.
   always @(posedge i_clock)
   begin
      if (!i_rst_b)
      begin
         div <= 0;
         o_other <= 1'b0;
         o_ticks <= 0;
      end
      else
      begin
         div <= (div == PERIOD - 1) ? 0 : div + 1;
         o_other <= (div == PERIOD - 1);
         o_ticks <= o_ticks + $countones(i_ticks);
      end
   end
endmodule

// ### bench/timer2_reload_capture_baud_tb_top.sv
`timescale 1ns/1ns
// Drives the timer through reload, capture, free, counter and baud modes.
module timer2_reload_capture_baud_tb_top;
   import timer2_pkg::*;
   localparam int OTHER_PERIOD = 10;
   logic i_clock, i_rst_b, i_timer_run, i_counter_mode, i_capture_select, i_trigger_enable;
   logic i_rx_baud_select, i_tx_baud_select, i_rx_baud_select_port1, i_tx_baud_select_port1;
   logic i_trigger_pin, i_count_input_pin, i_other_timer_tick, i_count_write, i_reload_write;
   logic i_overflow_clear, i_external_clear, o_overflow_flag, o_external_flag, o_baud_mode;
   logic o_rx_clock_port_a, o_tx_clock_port_a, o_rx_clock_port_b, o_tx_clock_port_b;
   logic [15:0] i_write_data, o_count, o_reload, m_reload, m_count, prev;
   logic [3:0]  tk;
   logic [31:0] seed = 32'h0001_697F;
   int          failures = 0, cmp_count = 0, cyc = 0, n, ticks;

   assign tk = {o_tx_clock_port_a, o_rx_clock_port_a, o_tx_clock_port_b, o_rx_clock_port_b};

   timer2_reload_capture_baud dut (.i_clock, .i_rst_b, .i_timer_run, .i_counter_mode, .i_capture_select,
      .i_trigger_enable, .i_rx_baud_select, .i_tx_baud_select, .i_rx_baud_select_port1,
      .i_tx_baud_select_port1, .i_trigger_pin, .i_count_input_pin, .i_other_timer_tick, .i_count_write,
      .i_reload_write, .i_write_data, .i_overflow_clear, .i_external_clear, .o_count, .o_reload,
      .o_overflow_flag, .o_external_flag, .o_baud_mode, .o_rx_clock_port_a, .o_tx_clock_port_a,
      .o_rx_clock_port_b, .o_tx_clock_port_b);

   baud_partner #(.PERIOD(OTHER_PERIOD)) peer (.i_clock, .i_rst_b, .i_ticks(tk), .o_other(i_other_timer_tick),
      .o_ticks(ticks));

   // The clock toggles every 10 ns, a period of 20 ns.
   always #10 i_clock = ~i_clock;

   // Cuts a hang short well beyond the several hundred cycles the run needs.
   always @(posedge i_clock)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         failures++;
         test_done();
      end
   end

   function automatic logic [15:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[15:0];
   endfunction

   // Model of the rules: cycles between two baud ticks for a given reload value.
   function automatic int baud_gap(input logic [15:0] rl);
      return BAUD_DIVIDE * DIV_BAUD * (32'h0001_0000 - int'(rl));
   endfunction

   task automatic step(input int k);
      repeat (k) @(posedge i_clock);
      #2;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         failures++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // A count write when sel is 1, a reload write otherwise.
   task automatic wr(input logic sel, input logic [15:0] d);
      i_count_write = sel;
      i_reload_write = ~sel;
      i_write_data = d;
      step(1);
      i_count_write = 1'b0;
      i_reload_write = 1'b0;
      // Lets an edge pass so that a following write never reassigns the strobes in one time step.
      step(1);
   endtask

   // Falls on the trigger pin (k=1) or count pin (k=0), each level held 12 cycles.
   task automatic fall(input logic k);
      if (k) i_trigger_pin = 1'b0; else i_count_input_pin = 1'b0;
      step(12);
      i_trigger_pin = 1'b1;
      i_count_input_pin = 1'b1;
      step(12);
   endtask

   task automatic clear_flags();
      i_overflow_clear = 1'b1;
      i_external_clear = 1'b1;
      step(1);
      i_overflow_clear = 1'b0;
      i_external_clear = 1'b0;
   endtask

   // Cycles between two ticks on baud output k.
   task automatic gap(input int k);
      n = 0;
      while (!tk[k] && n < 200) begin step(1); n++; end
      n = 0;
      do begin step(1); n++; end while (!tk[k] && n < 200);
   endtask

   task automatic test_done();
      if (failures == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial
   begin
      {i_clock, i_rst_b, i_timer_run, i_counter_mode, i_capture_select, i_trigger_enable} = '0;
      {i_rx_baud_select, i_tx_baud_select, i_rx_baud_select_port1, i_tx_baud_select_port1} = '0;
      {i_count_write, i_reload_write, i_overflow_clear, i_external_clear} = '0;
      {i_trigger_pin, i_count_input_pin, i_write_data} = {2'b11, 16'h0000};
      repeat (12) @(posedge i_clock);
      #2;
      i_rst_b = 1'b1;
      check(o_count, 16'h0000);
      check(o_reload, 16'h0000);
      check(16'({o_overflow_flag, o_external_flag}), 16'h0000);
      // Reload mode: step every 12 cycles, overflow loads the reload value and sets the flag.
      m_reload = 16'hFF00 | (rnd() & 16'h00FF);
      wr(0, m_reload);
      wr(1, 16'hFFFC);
      i_timer_run = 1'b1;
      prev = o_count;
      n = 0;
      while (o_count === prev && n < 40) begin step(1); n++; end
      prev = o_count;
      n = 0;
      do begin step(1); n++; end while (o_count === prev && n < 40);
      check(16'(n), 16'(DIV_TIMER));
      n = 0;
      while (o_overflow_flag !== 1'b1 && n < 60) begin step(1); n++; end
      check(o_count, m_reload);
      clear_flags();
      check(16'(o_overflow_flag), 16'h0000);
      i_timer_run = 1'b0;
      step(1);
      prev = o_count;
      step(30);
      check(o_count, prev);
      // Counter mode with a quiet pin keeps the count still for the trigger tests.
      {i_counter_mode, i_timer_run, i_trigger_enable} = 3'b111;
      wr(1, rnd());
      fall(1);
      check(o_count, m_reload);
      clear_flags();
      m_count = rnd();
      i_capture_select = 1'b1;
      wr(1, m_count);
      fall(1);
      check(o_reload, m_count);
      check(16'(o_external_flag), 16'h0001);
      clear_flags();
      // Free counting on pin falls, wrapping with no reload or capture.
      i_trigger_enable = 1'b0;
      wr(1, 16'hFFFE);
      fall(0);
      check(o_count, 16'hFFFF);
      fall(0);
      check(o_count, 16'h0000);
      check(16'(o_overflow_flag), 16'h0001);
      fall(1);
      check(o_reload, m_count);
      i_timer_run = 1'b0;
      fall(0);
      check(o_count, 16'h0000);
      // Baud mode: rollover every one to four steps of two cycles, one tick per 16 rollovers.
      {i_counter_mode, i_tx_baud_select, i_rx_baud_select_port1} = 3'b011;
      clear_flags();
      m_reload = 16'hFFFC | (rnd() & 16'h0003);
      wr(0, m_reload);
      wr(1, 16'hFFFE);
      i_timer_run = 1'b1;
      check(16'(o_baud_mode), 16'h0001);
      gap(3);
      check(16'(n), 16'(baud_gap(m_reload)));
      gap(0);
      check(16'(n), 16'(baud_gap(m_reload)));
      gap(2);
      check(16'(n), 16'(OTHER_PERIOD));
      gap(1);
      check(16'(n), 16'(OTHER_PERIOD));
      check(16'(ticks > 0), 16'h0001);
      check(16'(o_overflow_flag), 16'h0000);
      i_trigger_enable = 1'b1;
      wr(1, 16'h1000);
      fall(1);
      check(16'(o_external_flag), 16'h0001);
      check(16'(o_count[15:8]), 16'h0010);
      check(16'(o_overflow_flag), 16'h0000);
      // Port B's receive select alone keeps baud mode; port A transmit falls back to the other timer.
      i_tx_baud_select = 1'b0;
      step(1);
      check(16'(o_baud_mode), 16'h0001);
      gap(3);
      check(16'(n), 16'(OTHER_PERIOD));
      test_done();
   end
endmodule
